// file: src/vgs_regs.sv
// general and sequencer register bank with character clock sequencer
`timescale 1ns/1ps
module vgs_regs
    import vgs_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire logic [9:0]   io_addr,
    input  wire logic         io_rd,
    input  wire logic         io_wr,
    input  wire logic [7:0]   io_wdata,
    output logic [7:0]        io_rdata,
    output logic              io_hit,
    output logic              timing_unit_sel,
    input  wire logic         cfg_bit3,
    output vgs_clk_src_t      pixel_clock_source,
    output logic              cpu_vram_enable,
    input  wire logic         cpu_mem_write,
    output logic [3:0]        plane_write_enable,
    input  wire logic         retrace_irq_pending,
    input  wire logic         monitor_sense,
    input  wire logic [7:0]   pixel_attribute_bits,
    input  wire logic [1:0]   color_plane_select,
    input  wire logic         vert_retrace,
    input  wire logic         display_suppressed,
    input  wire logic         vsync_in,
    input  wire logic         vert_display_en,
    output logic              vsync_out,
    output logic              video_blank,
    input  wire logic         pixel_tick,
    output logic              sequencer_running,
    output logic              char_tick,
    output logic              shift_load,
    input  wire logic         ext_memory,
    input  wire logic         text_attr_bit3,
    input  wire logic         text_attr_bit4,
    input  wire logic         vendor_ext_bit2,
    input  wire logic         vendor_ext_bit5,
    output logic [2:0]        font_block,
    output logic              font_plane3
);
    logic [7:0] misc_q;
    logic [7:0] feat_q;
    logic [2:0] index_q;
    logic [7:0] rst_ctl_q;
    logic [7:0] clk_mode_q;
    logic [7:0] map_mask_q;
    logic [7:0] font_sel_q;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic       sense_meta_q;
    logic       sense_q;
    logic       dot_half_q;
    logic [3:0] pix_cnt_q;
    logic [1:0] char_cnt_q;
    logic       char_tick_q;
    logic       load_q;
    logic       vsync_q;
    logic       blank_q;
    logic [2:0] font_block_q;
    logic       plane3_q;

    logic       color_io;
    logic       hit_stat1;
    logic       hit_tu;
    logic       wr_misc;
    logic       wr_feat;
    logic       wr_idx;
    logic       wr_data;
    logic       run;
    logic       dot_en;
    logic [3:0] char_last;
    logic       char_end;
    logic       load_now;
    logic [1:0] diag;
    logic [2:0] map_a;
    logic [2:0] map_b;
    logic [2:0] map_code;

    // address decode
    assign color_io  = misc_q[MISC_IOSEL];
    assign hit_stat1 = color_io ? (io_addr == ADDR_COLR_STAT)
                                : (io_addr == ADDR_MONO_STAT);
    assign hit_tu    = color_io
                       ? (io_addr == ADDR_COLR_IDX || io_addr == ADDR_COLR_DATA)
                       : (io_addr == ADDR_MONO_IDX || io_addr == ADDR_MONO_DATA);
    assign timing_unit_sel = hit_tu && (io_rd || io_wr);

    assign wr_misc = clk_en && io_wr && io_addr == ADDR_MISC_WR;
    assign wr_feat = clk_en && io_wr && hit_stat1;
    assign wr_idx  = clk_en && io_wr && io_addr == ADDR_SEQ_IDX;
    assign wr_data = clk_en && io_wr && io_addr == ADDR_SEQ_DATA;

    always_comb begin
        io_hit = 1'b0;
        if (io_rd) begin
            io_hit = io_addr == ADDR_MISC_RD || io_addr == ADDR_STAT0 || hit_stat1
                     || io_addr == ADDR_FEAT_RD || io_addr == ADDR_SEQ_IDX
                     || io_addr == ADDR_SEQ_DATA;
        end else if (io_wr) begin
            io_hit = io_addr == ADDR_MISC_WR || hit_stat1 || io_addr == ADDR_SEQ_IDX
                     || io_addr == ADDR_SEQ_DATA;
        end
    end

    // general registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            misc_q <= MISC_RESET;
        end else if (wr_misc) begin
            misc_q <= io_wdata & MISC_WMASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            feat_q <= FEAT_RESET;
        end else if (wr_feat) begin
            feat_q <= io_wdata & FEAT_WMASK;
        end
    end

    // sequencer index and indexed registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            index_q <= IDX_RESET;
        end else if (wr_idx) begin
            index_q <= io_wdata[2:0];
        end
    end

    // an index above the last register falls through: writes are dropped
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rst_ctl_q  <= RST_RESET;
            clk_mode_q <= CLK_RESET;
            map_mask_q <= MASK_RESET;
            font_sel_q <= FONT_RESET;
        end else if (wr_data) begin
            unique case (index_q)
                IDX_RESET: rst_ctl_q  <= io_wdata & RST_WMASK;
                IDX_CLOCK: clk_mode_q <= io_wdata & CLK_WMASK;
                IDX_MASK:  map_mask_q <= io_wdata & MASK_WMASK;
                IDX_FONT:  font_sel_q <= io_wdata & FONT_WMASK;
                default:   ;
            endcase
        end
    end

    // monitor comparator is asynchronous to sys_clk
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sense_meta_q <= 1'b0;
            sense_q      <= 1'b0;
        end else if (clk_en) begin
            sense_meta_q <= monitor_sense;
            sense_q      <= sense_meta_q;
        end
    end

    always_comb begin
        unique case (color_plane_select)
            2'b00:   diag = {pixel_attribute_bits[2], pixel_attribute_bits[0]};
            2'b01:   diag = {pixel_attribute_bits[5], pixel_attribute_bits[4]};
            2'b10:   diag = {pixel_attribute_bits[3], pixel_attribute_bits[1]};
            2'b11:   diag = {pixel_attribute_bits[7], pixel_attribute_bits[6]};
        endcase
    end

    // read mux; the memory mode register lives outside this bank
    always_comb begin
        rdata_d = 8'h00;
        if (io_addr == ADDR_MISC_RD) begin
            rdata_d = misc_q;
        end else if (io_addr == ADDR_STAT0) begin
            rdata_d = {retrace_irq_pending, 2'b00, sense_q, 4'h0};
        end else if (hit_stat1) begin
            rdata_d = {2'b00, diag, vert_retrace, 2'b00, display_suppressed};
        end else if (io_addr == ADDR_FEAT_RD) begin
            rdata_d = feat_q;
        end else if (io_addr == ADDR_SEQ_IDX) begin
            rdata_d = {5'h00, index_q};
        end else if (io_addr == ADDR_SEQ_DATA) begin
            unique case (index_q)
                IDX_RESET: rdata_d = rst_ctl_q;
                IDX_CLOCK: rdata_d = clk_mode_q;
                IDX_MASK:  rdata_d = map_mask_q;
                IDX_FONT:  rdata_d = font_sel_q;
                default:   rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (clk_en && io_rd) begin
            rdata_q <= rdata_d;
        end
    end
    assign io_rdata = rdata_q;

    // clock source and memory access control
    always_comb begin
        unique case ({misc_q[MISC_CS1], misc_q[MISC_CS0]})
            2'b00:   pixel_clock_source = VGS_CLK_ZERO;
            2'b01:   pixel_clock_source = VGS_CLK_ONE;
            2'b10:   pixel_clock_source = cfg_bit3 ? VGS_CLK_NONE : VGS_CLK_USER;
            2'b11:   pixel_clock_source = cfg_bit3 ? VGS_CLK_NONE : VGS_CLK_USER;
        endcase
    end

    assign cpu_vram_enable    = misc_q[MISC_VRAM];
    assign plane_write_enable = {4{cpu_mem_write && misc_q[MISC_VRAM]}}
                                & map_mask_q[3:0];

    // async reset bit gates the run level with no register in between
    assign run = rst_ctl_q[RST_SYNC] && rst_ctl_q[RST_ASYNC];
    assign sequencer_running = run;

    assign dot_en    = pixel_tick && (!clk_mode_q[CLK_DIV2] || dot_half_q);
    assign char_last = clk_mode_q[CLK_DOT8] ? CHAR_LAST_8 : CHAR_LAST_9;
    assign char_end  = dot_en && pix_cnt_q >= char_last;

    always_comb begin
        if (clk_mode_q[CLK_LOAD4]) begin
            load_now = char_cnt_q == LOAD4_LAST;
        end else if (clk_mode_q[CLK_LOAD2]) begin
            load_now = char_cnt_q[0];
        end else begin
            load_now = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run) begin
            dot_half_q <= 1'b0;
        end else if (clk_en && pixel_tick) begin
            dot_half_q <= clk_mode_q[CLK_DIV2] ? !dot_half_q : 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run) begin
            pix_cnt_q  <= 4'h0;
            char_cnt_q <= 2'b00;
        end else if (clk_en && dot_en) begin
            if (char_end) begin
                pix_cnt_q  <= 4'h0;
                char_cnt_q <= char_cnt_q + 2'b01;
            end else begin
                pix_cnt_q <= pix_cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run) begin
            char_tick_q <= 1'b0;
            load_q      <= 1'b0;
        end else if (clk_en) begin
            char_tick_q <= char_end;
            load_q      <= char_end && load_now;
        end
    end
    // asynchronous halt kills the strobes in the same cycle
    assign char_tick  = char_tick_q && rst_ctl_q[RST_ASYNC];
    assign shift_load = load_q && rst_ctl_q[RST_ASYNC];

    // sync and blank outputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            vsync_q <= 1'b0;
            blank_q <= 1'b1;
        end else if (clk_en) begin
            vsync_q <= feat_q[FEAT_VSYNC] ? (vsync_in || vert_display_en)
                                          : vsync_in;
            blank_q <= clk_mode_q[CLK_SCROFF] || display_suppressed;
        end
    end
    assign vsync_out   = vsync_q;
    assign video_blank = blank_q;

    // font map selection
    assign map_a    = {font_sel_q[5], font_sel_q[3], font_sel_q[2]};
    assign map_b    = {font_sel_q[4], font_sel_q[1], font_sel_q[0]};
    assign map_code = (ext_memory && !text_attr_bit3) ? map_b : map_a;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            font_block_q <= 3'h0;
            plane3_q     <= 1'b0;
        end else if (clk_en) begin
            font_block_q <= {map_code[1:0], map_code[2]};
            plane3_q     <= vendor_ext_bit2
                            && (vendor_ext_bit5 ? text_attr_bit4 : 1'b1);
        end
    end
    assign font_block  = font_block_q;
    assign font_plane3 = plane3_q;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_stat1_decode: assert property (
        (io_rd && io_addr == ADDR_COLR_STAT && clk_en) |-> (io_hit == color_io))
        else $error("status one decode wrong for address select");

    chk_stat0_irq: assert property (
        (clk_en && io_rd && io_addr == ADDR_STAT0) |=> io_rdata[7] == $past(retrace_irq_pending))
        else $error("status zero bit 7 not irq pending");

    chk_sense_read: assert property (
        (clk_en && io_rd && io_addr == ADDR_STAT0) |=> io_rdata[4] == $past(sense_q))
        else $error("monitor detect not in status zero");

    chk_stat1_retrace: assert property (
        (clk_en && io_rd && hit_stat1) |=>
            io_rdata[3] == $past(vert_retrace) && io_rdata[0] == $past(display_suppressed))
        else $error("status one retrace bits wrong");

    chk_diag_pair: assert property (
        (clk_en && io_rd && hit_stat1 && color_plane_select == 2'b01)
            |=> io_rdata[5:4] == $past(pixel_attribute_bits[5:4]))
        else $error("diagnostic pair wrong");

    chk_vsync_gate: assert property (
        (clk_en && feat_q[FEAT_VSYNC] && vert_display_en) |=> vsync_out)
        else $error("vsync not ORed with display enable");

    chk_bad_index: assert property (
        (clk_en && io_rd && io_addr == ADDR_SEQ_DATA && index_q > IDX_MEM) |=> io_rdata == 8'h00)
        else $error("index above range did not read zero");

    chk_index_write: assert property (
        wr_idx |=> index_q == $past(io_wdata[2:0]))
        else $error("index not stored");

    // sequencer strobes and counters
    chk_halt_strobes: assert property (
        !rst_ctl_q[RST_ASYNC] |-> !char_tick && !shift_load)
        else $error("strobe while asynchronously halted");

    chk_sync_halt: assert property (
        !rst_ctl_q[RST_SYNC] |=> pix_cnt_q == 4'h0 && !char_tick)
        else $error("sequencer not cleared by sync reset");

    chk_char_width: assert property (
        (clk_en && dot_en && run && pix_cnt_q == CHAR_LAST_8 && !clk_mode_q[CLK_DOT8]
            && $stable(clk_mode_q)) |=> !char_tick)
        else $error("nine dot character ended at eight");

    chk_load_four: assert property (
        (shift_load && clk_mode_q[CLK_LOAD4] && $stable(clk_mode_q)) |-> char_cnt_q == 2'b00)
        else $error("four-character load at wrong phase");

    chk_load_every: assert property (
        (clk_en && run && char_end && !clk_mode_q[CLK_LOAD4] && !clk_mode_q[CLK_LOAD2])
            |=> shift_load || !rst_ctl_q[RST_ASYNC])
        else $error("serializer not loaded every character");

    // memory access and blanking
    chk_plane_mask: assert property (
        (cpu_mem_write && cpu_vram_enable) |-> plane_write_enable == map_mask_q[3:0])
        else $error("plane write enable not from map mask");

    chk_vram_block: assert property (
        !cpu_vram_enable |-> plane_write_enable == 4'h0)
        else $error("plane write while memory blocked");

    chk_screen_off: assert property (
        (clk_en && clk_mode_q[CLK_SCROFF]) |=> video_blank)
        else $error("screen off did not blank");
endmodule

// file: shared/vgs_pkg.sv
// constants of the general and sequencer register bank
// Function
// - clock-select 00/01 pick input zero/one; 10/11 pick user clock if config bit3=0
// - miscellaneous bit 1 zero blocks processor video memory access, one allows it
// - address-select bit picks 3Bx or 3Dx for timing ports and status one
// - status zero bit 7 shows retrace interrupt pending
// - status zero bit 4 returns monitor detect; host samples it in active video
// - status one bits 5:4 return attribute bit pair chosen by plane-enable code
// - status one bit 3 is one during vertical retrace
// - status one bit 0 is one while display is suppressed for retrace
// - feature bit 3 ORs vertical display enable into vertical sync output
// - host writes index 0 to 4; index selects sequencer data register
// - synchronous reset bit zero clears and halts sequencer synchronously
// - asynchronous reset bit zero halts at once; run only when both bits one
// - screen-off bit blanks picture while syncs keep running
// - clocking bit 4 one reloads serializers every fourth character clock
// - bit 4 zero reloads every character, or every other if bit 2 one
// - clocking bit 3 one divides pixel clock by two
// - character clock is nine pixels wide when bit 0 zero, eight when one
// - map-mask bits 3:0 each permit processor writes to planes 0 to 3
// - font map A code from bits 5,3,2; map B from bits 4,1,0
// - with extended memory, attribute bit 3 picks map A (one) or B (zero)
// - font plane 2 or 3 chosen by two vendor bits and attribute bit 4
// - font code 0..7 maps to 8 KiB blocks 1,3,5,7,2,4,6,8
// - extended-memory bit one means more than 64 KiB of video memory
package vgs_pkg;
    localparam logic [9:0] ADDR_MISC_WR   = 10'h3C2;
    localparam logic [9:0] ADDR_MISC_RD   = 10'h3CC;
    localparam logic [9:0] ADDR_STAT0     = 10'h3C2;
    localparam logic [9:0] ADDR_SEQ_IDX   = 10'h3C4;
    localparam logic [9:0] ADDR_SEQ_DATA  = 10'h3C5;
    localparam logic [9:0] ADDR_FEAT_RD   = 10'h3CA;
    localparam logic [9:0] ADDR_MONO_IDX  = 10'h3B4;
    localparam logic [9:0] ADDR_MONO_DATA = 10'h3B5;
    localparam logic [9:0] ADDR_MONO_STAT = 10'h3BA;
    localparam logic [9:0] ADDR_COLR_IDX  = 10'h3D4;
    localparam logic [9:0] ADDR_COLR_DATA = 10'h3D5;
    localparam logic [9:0] ADDR_COLR_STAT = 10'h3DA;

    localparam logic [2:0] IDX_RESET = 3'h0;
    localparam logic [2:0] IDX_CLOCK = 3'h1;
    localparam logic [2:0] IDX_MASK  = 3'h2;
    localparam logic [2:0] IDX_FONT  = 3'h3;
    localparam logic [2:0] IDX_MEM   = 3'h4;

    // writable bit masks; reserved bits are never stored and read zero
    localparam logic [7:0] MISC_WMASK  = 8'hEF;
    localparam logic [7:0] FEAT_WMASK  = 8'h08;
    localparam logic [7:0] RST_WMASK   = 8'h03;
    localparam logic [7:0] CLK_WMASK   = 8'h3D;
    localparam logic [7:0] MASK_WMASK  = 8'h0F;
    localparam logic [7:0] FONT_WMASK  = 8'h3F;
    localparam logic [7:0] IDX_WMASK   = 8'h07;

    localparam logic [7:0] MISC_RESET  = 8'h00;
    localparam logic [7:0] FEAT_RESET  = 8'h00;
    localparam logic [7:0] RST_RESET   = 8'h03;
    localparam logic [7:0] CLK_RESET   = 8'h00;
    localparam logic [7:0] MASK_RESET  = 8'h0F;
    localparam logic [7:0] FONT_RESET  = 8'h00;

    localparam int MISC_IOSEL = 0;
    localparam int MISC_VRAM  = 1;
    localparam int MISC_CS0   = 2;
    localparam int MISC_CS1   = 3;
    localparam int FEAT_VSYNC = 3;
    localparam int RST_ASYNC  = 0;
    localparam int RST_SYNC   = 1;
    localparam int CLK_DOT8   = 0;
    localparam int CLK_LOAD2  = 2;
    localparam int CLK_DIV2   = 3;
    localparam int CLK_LOAD4  = 4;
    localparam int CLK_SCROFF = 5;

    localparam logic [3:0] CHAR_LAST_9 = 4'h8;
    localparam logic [3:0] CHAR_LAST_8 = 4'h7;
    localparam logic [1:0] LOAD4_LAST  = 2'h3;

    typedef enum logic [1:0] {
        VGS_CLK_ZERO,
        VGS_CLK_ONE,
        VGS_CLK_USER,
        VGS_CLK_NONE
    } vgs_clk_src_t;
endpackage

// file: dv/vgs_host.sv
// host processor model driving the I/O port strobes of the register bank
`timescale 1ns/1ps
module vgs_host (
    input  wire logic       sys_clk,
    input  wire logic [7:0] io_rdata,
    input  wire logic       snoop,
    output logic [9:0]      io_addr,
    output logic            io_rd,
    output logic            io_wr,
    output logic [7:0]      io_wdata,
    output logic            snoop_seen
);
    initial begin
        io_addr    = 10'h000;
        io_rd      = 1'b0;
        io_wr      = 1'b0;
        io_wdata   = 8'h00;
        snoop_seen = 1'b0;
    end

    // callers always pass reserved bits as zero
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge sys_clk);
        io_wr    <= 1'b0;
        // released bus shows inverted values, not the last ones
        io_addr  <= ~a;
        io_wdata <= ~d;
    endtask

    // index is written before the data port access that uses it
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge sys_clk);
        snoop_seen = snoop;
        io_rd   <= 1'b0;
        io_addr <= ~a;
        #1;
        d = io_rdata;
    endtask
endmodule

// file: dv/tb_vgs_regs.sv
// self-checking bench for the general and sequencer register bank
`timescale 1ns/1ps
module tb_vgs_regs;
    import vgs_pkg::*;
    logic sys_clk, rst_n, clk_en, cfg_bit3, cpu_mem_write, retrace_irq_pending, monitor_sense;
    logic vert_retrace, display_suppressed, vsync_in, vert_display_en, pixel_tick, ext_memory;
    logic text_attr_bit3, text_attr_bit4, vendor_ext_bit2, vendor_ext_bit5, snoop_seen;
    logic io_rd, io_wr, io_hit, timing_unit_sel, cpu_vram_enable, vsync_out, video_blank;
    logic sequencer_running, char_tick, shift_load, font_plane3, hit_seen;
    logic [9:0]   io_addr;
    logic [7:0]   io_wdata, io_rdata, pixel_attribute_bits;
    logic [3:0]   plane_write_enable;
    logic [2:0]   font_block;
    logic [1:0]   color_plane_select;
    vgs_clk_src_t pixel_clock_source;
    int           error_cnt, comparisons, cyc, n, b;
    localparam logic [7:0] CV [7] = '{8'h00, 8'h00, 8'h04, 8'h10, 8'h01, 8'h08, 8'h09};
    localparam logic [7:0] CE [7] = '{8'd9, 8'd9, 8'd18, 8'd36, 8'd8, 8'd18, 8'd16};
    localparam bit         CS [7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    localparam logic [7:0] RV [5] = '{8'h03, 8'h00, 8'h0F, 8'h00, 8'h00};
    localparam logic [2:0] FB [8] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h1, 3'h3, 3'h5, 3'h7};

    vgs_regs vgs_regs_i (.sys_clk, .rst_n, .clk_en, .io_addr, .io_rd, .io_wr, .io_wdata,
        .io_rdata, .io_hit, .timing_unit_sel, .cfg_bit3, .pixel_clock_source, .cpu_vram_enable,
        .cpu_mem_write, .plane_write_enable, .retrace_irq_pending, .monitor_sense,
        .pixel_attribute_bits, .color_plane_select, .vert_retrace, .display_suppressed,
        .vsync_in, .vert_display_en, .vsync_out, .video_blank, .pixel_tick, .sequencer_running,
        .char_tick, .shift_load, .ext_memory, .text_attr_bit3, .text_attr_bit4,
        .vendor_ext_bit2, .vendor_ext_bit5, .font_block, .font_plane3);
    vgs_host vgs_host_i (.sys_clk, .io_rdata, .snoop(timing_unit_sel), .io_addr, .io_rd,
        .io_wr, .io_wdata, .snoop_seen);

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge sys_clk) if (io_rd || io_wr) hit_seen <= io_hit;

    // run should take about 1500 cycles; a hang is cut short here
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [9:0] a, input logic [7:0] exp, input string msg);
        logic [7:0] d;
        vgs_host_i.rd(a, d);
        check(d, exp, msg);
    endtask
    task automatic seq(input logic [2:0] i, input logic [7:0] d);
        vgs_host_i.wr(ADDR_SEQ_IDX, {5'h00, i});
        vgs_host_i.wr(ADDR_SEQ_DATA, d);
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    // cycles between two strobes, 200 when none comes
    task automatic gap(input bit sl, output int g);
        int i;
        i = 0;
        g = 0;
        while ((sl ? shift_load : char_tick) !== 1'b1 && i < 200) begin
            settle(1);
            i++;
        end
        do begin
            settle(1);
            g++;
        end while ((sl ? shift_load : char_tick) !== 1'b1 && g < 200);
    endtask
    function automatic logic [1:0] pair(input logic [1:0] k, input logic [7:0] a);
        case (k)
            2'd0: pair = {a[2], a[0]};
            2'd1: pair = {a[5], a[4]};
            2'd2: pair = {a[3], a[1]};
            default: pair = {a[7], a[6]};
        endcase
    endfunction

    initial begin
        {rst_n, cfg_bit3, cpu_mem_write, retrace_irq_pending, monitor_sense} = 5'b0;
        {vert_retrace, display_suppressed, vsync_in, vert_display_en, ext_memory} = 5'b0;
        {text_attr_bit3, text_attr_bit4, vendor_ext_bit2, vendor_ext_bit5} = 4'b0;
        clk_en = 1'b1;
        pixel_tick = 1'b1;
        pixel_attribute_bits = 8'h96;
        color_plane_select = 2'd0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdchk(ADDR_MISC_RD, 8'h00, "misc reset");
        rdchk(ADDR_FEAT_RD, 8'h00, "feature reset");
        for (int i = 0; i < 5; i++) begin
            vgs_host_i.wr(ADDR_SEQ_IDX, 8'(i));
            rdchk(ADDR_SEQ_DATA, RV[i], "sequencer reset value");
        end
        seq(3'd5, 8'h0F);
        rdchk(ADDR_SEQ_DATA, 8'h00, "index above four");
        rdchk(ADDR_SEQ_IDX, 8'h05, "index readback");
        vgs_host_i.wr(ADDR_SEQ_IDX, 8'h02);
        rdchk(ADDR_SEQ_DATA, 8'h0F, "mask untouched");
        for (int c = 0; c < 8; c++) begin
            @(posedge sys_clk);
            cfg_bit3 <= c[0];
            vgs_host_i.wr(ADDR_MISC_WR, {4'h0, c[2:1], 2'b00});
            settle(1);
            b = (c < 4) ? c / 2 : (c[0] ? 3 : 2);
            check({6'h00, pixel_clock_source}, 8'(b), "clock source");
        end
        seq(IDX_MASK, 8'h05);
        @(posedge sys_clk);
        cpu_mem_write <= 1'b1;
        vgs_host_i.wr(ADDR_MISC_WR, 8'h02);
        settle(1);
        check({7'h00, cpu_vram_enable}, 8'h01, "vram enable");
        check({4'h0, plane_write_enable}, 8'h05, "plane enables");
        vgs_host_i.wr(ADDR_MISC_WR, 8'h00);
        settle(1);
        check({4'h0, plane_write_enable}, 8'h00, "vram blocked");
        check({7'h00, cpu_vram_enable}, 8'h00, "vram off");
        rdchk(ADDR_MONO_IDX, 8'h00, "mono index");
        check({7'h00, snoop_seen}, 8'h01, "mono select");
        rdchk(ADDR_MONO_STAT, {2'b0, pair(2'd0, 8'h96), 4'h0}, "mono status");
        check({7'h00, hit_seen}, 8'h01, "mono hit");
        vgs_host_i.wr(ADDR_MISC_WR, 8'h01);
        rdchk(ADDR_MONO_STAT, 8'h00, "mono status unmapped");
        check({7'h00, hit_seen}, 8'h00, "unmapped hit");
        vgs_host_i.wr(ADDR_COLR_IDX, 8'h00);
        rdchk(ADDR_COLR_IDX, 8'h00, "color index");
        check({7'h00, snoop_seen}, 8'h01, "color select");
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            color_plane_select <= 2'(k);
            vert_retrace <= k[0];
            display_suppressed <= k[1];
            settle(2);
            rdchk(ADDR_COLR_STAT, {2'b0, pair(2'(k), 8'h96), k[0], 2'b0, k[1]},
                  "status one");
        end
        vgs_host_i.wr(ADDR_COLR_STAT, 8'h08);
        rdchk(ADDR_FEAT_RD, 8'h08, "feature readback");
        @(posedge sys_clk);
        vert_display_en <= 1'b1;
        display_suppressed <= 1'b0;
        vert_retrace <= 1'b0;
        settle(3);
        check({7'h00, vsync_out}, 8'h01, "sync or enable");
        vgs_host_i.wr(ADDR_COLR_STAT, 8'h00);
        settle(3);
        check({7'h00, vsync_out}, 8'h00, "plain sync");
        @(posedge sys_clk);
        retrace_irq_pending <= 1'b1;
        monitor_sense <= 1'b1;
        settle(4);
        rdchk(ADDR_STAT0, 8'h90, "status zero set");
        @(posedge sys_clk);
        monitor_sense <= 1'b0;
        settle(4);
        rdchk(ADDR_STAT0, 8'h80, "status zero sense low");
        @(posedge sys_clk);
        retrace_irq_pending <= 1'b0;
        settle(2);
        rdchk(ADDR_STAT0, 8'h00, "status zero cleared");
        seq(IDX_CLOCK, 8'h20);
        settle(2);
        check({7'h00, video_blank}, 8'h01, "screen off");
        gap(1'b0, n);
        check(n[7:0], 8'd9, "ticks while off");
        for (int i = 0; i < 7; i++) begin
            seq(IDX_CLOCK, CV[i]);
            gap(CS[i], n);
            gap(CS[i], n);
            check(n[7:0], CE[i], "strobe period");
        end
        check({7'h00, video_blank}, 8'h00, "screen on");
        seq(IDX_CLOCK, 8'h00);
        for (int i = 1; i < 4; i++) begin
            seq(IDX_RESET, 8'(i));
            settle(1);
            check({7'h00, sequencer_running}, 8'(i == 3), "running");
            gap(1'b0, n);
            check(n[7:0], (i == 3) ? 8'd9 : 8'd200, "halted ticks");
        end
        for (int c = 0; c < 8; c++) begin
            b = 7 - c;
            seq(IDX_FONT, {2'b0, c[2], b[2], c[1:0], b[1:0]});
            @(posedge sys_clk);
            ext_memory <= 1'b0;
            settle(2);
            check({5'h00, font_block}, {5'h00, FB[c]}, "map a");
            @(posedge sys_clk);
            ext_memory <= 1'b1;
            text_attr_bit3 <= 1'b0;
            settle(2);
            check({5'h00, font_block}, {5'h00, FB[b]}, "map b");
            @(posedge sys_clk);
            text_attr_bit3 <= 1'b1;
            settle(2);
            check({5'h00, font_block}, {5'h00, FB[c]}, "attr map a");
        end
        for (int v = 0; v < 8; v++) begin
            @(posedge sys_clk);
            {vendor_ext_bit2, vendor_ext_bit5, text_attr_bit4} <= 3'(v);
            settle(2);
            check({7'h00, font_plane3}, 8'(v[2] & (v[1] ? v[0] : 1)), "font plane");
        end
        @(posedge sys_clk);
        clk_en <= 1'b0;
        vgs_host_i.wr(ADDR_SEQ_IDX, 8'h04);
        clk_en <= 1'b1;
        rdchk(ADDR_SEQ_IDX, 8'h03, "write frozen by clock enable");
        summarize();
    end
endmodule
